// File: hw/hfsc_params.svh
// Purpose: Constants for the HDLC FIFO status and control block
// Assumes: 256-byte receive and transmit FIFOs, byte-wide host and engine ports
// Notes:   Status bit positions are given as field positions
`ifndef HFSC_PARAMS_SVH
`define HFSC_PARAMS_SVH

`define HFSC_FIFO_DEPTH      256
`define HFSC_PTR_W           8
`define HFSC_CNT_W           9
`define HFSC_RX_RESTART_FREE 9'h010
`define HFSC_RX_LVL_RST      8'h00
`define HFSC_TX_LVL_RST      8'h00
`define HFSC_IE_RST          8'h00
`define HFSC_RXS_AVAIL_BIT   0
`define HFSC_RXS_EMPTY_BIT   1
`define HFSC_RXL_AVAIL_BIT   0
`define HFSC_RXL_INVRD_BIT   1
`define HFSC_RXL_ABORT_BIT   2
`define HFSC_RXL_OVF_BIT     7
`define HFSC_TXS_AVAIL_BIT   0
`define HFSC_TXS_FULL_BIT    1
`define HFSC_TXL_AVAIL_BIT   0
`define HFSC_TXL_UNF_BIT     1
`define HFSC_TXL_OVF_BIT     2

`endif

// File: hw/hfsc_pkg.sv
// Purpose: Types for the HDLC FIFO status and control block
// Assumes: Constants come from hfsc_params.svh
// Notes:   Byte plus packet-start/abort tag is the FIFO word
package hfsc_pkg;
  typedef struct packed {
    logic       start;
    logic       abort;
    logic [7:0] data;
  } hfsc_word_t;

  typedef enum logic [0:0] {
    HFSC_RX_ACCEPT = 1'b0,
    HFSC_RX_DROP   = 1'b1
  } hfsc_rx_mode_t;
endpackage : hfsc_pkg

// File: hw/hfsc_mem.sv
// Purpose: FIFO storage with registered read data
// Assumes: One write and one read port on the system clock
// Notes:   Read data appear one cycle after the read address
`timescale 1ns/100ps
`include "hfsc_params.svh"
module hfsc_mem (
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_we,
  input  wire logic [`HFSC_PTR_W-1:0]      i_waddr,
  input  wire hfsc_pkg::hfsc_word_t        i_wdata,
  input  wire logic [`HFSC_PTR_W-1:0]      i_raddr,
  output hfsc_pkg::hfsc_word_t             o_rdata
);
  hfsc_pkg::hfsc_word_t mem_r [0:`HFSC_FIFO_DEPTH-1];

  always_ff @(posedge i_clk_sys) begin
    if (i_we) begin
      mem_r[i_waddr] <= i_wdata;
    end
    o_rdata <= mem_r[i_raddr];
  end
endmodule : hfsc_mem

// File: hw/hfsc_top.sv
// Purpose: Receive and transmit 256-byte FIFO control, status and interrupt
// Assumes: Host and HDLC engine strobes are synchronous to i_clk_sys
// Notes:   Read data return one cycle after the request strobe
`timescale 1ns/100ps
`include "hfsc_params.svh"
module hfsc_top (
  input  wire logic                     i_clk_sys,
  input  wire logic                     i_nrst,
  input  wire logic [7:0]               i_rx_fifo_level_ctrl,
  input  wire logic [7:0]               i_tx_fifo_level_ctrl,
  input  wire logic [7:0]               i_rx_irq_enable,
  input  wire logic [7:0]               i_tx_irq_enable,
  input  wire logic                     i_rx_wr_valid,
  input  wire hfsc_pkg::hfsc_word_t     i_rx_wr_word,
  input  wire logic                     i_rx_rd,
  output hfsc_pkg::hfsc_word_t          o_rx_rd_word,
  output logic                          o_rx_rd_valid,
  output logic                          o_rx_rd_invalid,
  input  wire logic                     i_tx_wr,
  input  wire logic [7:0]               i_tx_wr_data,
  input  wire logic                     i_tx_fetch,
  output logic [7:0]                    o_tx_fetch_data,
  output logic                          o_tx_fetch_valid,
  input  wire logic                     i_rxl_rd,
  input  wire logic                     i_rxl_clr_wr,
  input  wire logic [7:0]               i_rxl_clr,
  input  wire logic                     i_txl_rd,
  input  wire logic                     i_txl_clr_wr,
  input  wire logic [7:0]               i_txl_clr,
  output logic [7:0]                    o_rx_realtime_status,
  output logic [7:0]                    o_tx_realtime_status,
  output logic [8:0]                    o_tx_free_count_status,
  output logic [7:0]                    o_rx_latched_status,
  output logic [7:0]                    o_tx_latched_status,
  output logic                          o_irq_out_n
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [`HFSC_PTR_W-1:0]  rx_wp;
    logic [`HFSC_PTR_W-1:0]  rx_rp;
    logic [`HFSC_CNT_W-1:0]  rx_cnt;
    hfsc_pkg::hfsc_rx_mode_t rx_mode;
    logic                    rx_pend_abort;
    logic                    rx_rd_valid;
    logic                    rx_rd_inv;
    logic [`HFSC_PTR_W-1:0]  tx_wp;
    logic [`HFSC_PTR_W-1:0]  tx_rp;
    logic [`HFSC_CNT_W-1:0]  tx_cnt;
    logic                    tx_fv;
    logic [7:0]              rxs;
    logic [7:0]              txs;
    logic [8:0]              txfree;
    logic [7:0]              rxl;
    logic [7:0]              txl;
    logic [7:0]              rx_arm;
    logic [7:0]              tx_arm;
    logic                    irq_n;
  } hfsc_state_t;

  hfsc_state_t          st_r;
  hfsc_state_t          st_nxt;
  hfsc_pkg::hfsc_word_t rx_mem_wdata;
  logic                 rx_mem_we;
  hfsc_pkg::hfsc_word_t rx_mem_rdata;
  hfsc_pkg::hfsc_word_t tx_mem_rdata;
  logic                 tx_mem_we;
  hfsc_pkg::hfsc_word_t tx_mem_wdata;

  // Latched set wins over same-cycle clear
  function automatic logic [7:0] latch_upd(input logic [7:0] cur, input logic [7:0] set,
                                           input logic clr_wr, input logic [7:0] clr);
    latch_upd = ((clr_wr ? (cur & ~clr) : cur)) | set;
  endfunction : latch_upd

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  hfsc_mem u_rx_mem (
    .i_clk_sys (i_clk_sys),
    .i_we      (rx_mem_we),
    .i_waddr   (st_r.rx_wp),
    .i_wdata   (rx_mem_wdata),
    .i_raddr   (st_r.rx_rp),
    .o_rdata   (rx_mem_rdata)
  );

  hfsc_mem u_tx_mem (
    .i_clk_sys (i_clk_sys),
    .i_we      (tx_mem_we),
    .i_waddr   (st_r.tx_wp),
    .i_wdata   (tx_mem_wdata),
    .i_raddr   (st_r.tx_rp),
    .o_rdata   (tx_mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  logic                   rx_full;
  logic                   rx_empty;
  logic                   tx_full;
  logic                   tx_empty;
  logic                   rx_pop;
  logic                   tx_pop;
  logic [`HFSC_CNT_W-1:0] rx_free;
  logic [7:0]             rx_set;
  logic [7:0]             tx_set;
  logic [`HFSC_CNT_W-1:0] rx_cnt_n;
  logic [`HFSC_CNT_W-1:0] tx_cnt_n;
  logic                   rx_take;

  always_comb begin
    st_nxt       = st_r;
    rx_full      = (st_r.rx_cnt == 9'(`HFSC_FIFO_DEPTH));
    rx_empty     = (st_r.rx_cnt == 9'h000);
    tx_full      = (st_r.tx_cnt == 9'(`HFSC_FIFO_DEPTH));
    tx_empty     = (st_r.tx_cnt == 9'h000);
    rx_free      = 9'(`HFSC_FIFO_DEPTH) - st_r.rx_cnt;
    rx_set       = 8'h00;
    tx_set       = 8'h00;
    rx_take      = 1'b0;
    rx_mem_we    = 1'b0;
    rx_mem_wdata = i_rx_wr_word;
    tx_mem_we    = 1'b0;
    tx_mem_wdata = '{start: 1'b0, abort: 1'b0, data: i_tx_wr_data};

    // Receive read side
    rx_pop            = i_rx_rd && !rx_empty;
    st_nxt.rx_rd_valid = rx_pop;
    st_nxt.rx_rd_inv   = i_rx_rd && rx_empty;
    if (i_rx_rd && rx_empty) begin
      rx_set[`HFSC_RXL_INVRD_BIT] = 1'b1;
    end
    if (rx_pop) begin
      st_nxt.rx_rp = st_r.rx_rp + 8'h01;
    end

    // Receive write side with overflow recovery
    // Any word into a full FIFO is an overflow, also while already dropping
    if (i_rx_wr_valid) begin
      if (rx_full) begin
        rx_set[`HFSC_RXL_OVF_BIT] = 1'b1;
        st_nxt.rx_mode            = hfsc_pkg::HFSC_RX_DROP;
        if (!i_rx_wr_word.start) begin
          st_nxt.rx_pend_abort       = 1'b1;
          rx_set[`HFSC_RXL_ABORT_BIT] = 1'b1;
        end
      end else if (st_r.rx_mode == hfsc_pkg::HFSC_RX_DROP) begin
        if (i_rx_wr_word.start && (rx_free >= `HFSC_RX_RESTART_FREE)) begin
          st_nxt.rx_mode = hfsc_pkg::HFSC_RX_ACCEPT;
          rx_take        = 1'b1;
        end
      end else begin
        rx_take = 1'b1;
      end
    end
    if (rx_take) begin
      rx_mem_we          = 1'b1;
      rx_mem_wdata.abort = i_rx_wr_word.abort;
      st_nxt.rx_wp       = st_r.rx_wp + 8'h01;
    end
    // Abort tag rides only on a stored non-start word; drop mode stores only start words
    if (rx_take && st_r.rx_pend_abort && !i_rx_wr_word.start) begin
      rx_mem_wdata.abort   = 1'b1;
    end
    if (rx_take) begin
      st_nxt.rx_pend_abort = 1'b0;
    end
    rx_cnt_n = st_r.rx_cnt + {8'h00, rx_take} - {8'h00, rx_pop};
    st_nxt.rx_cnt = rx_cnt_n;

    // Transmit host write
    if (i_tx_wr) begin
      if (tx_full) begin
        tx_set[`HFSC_TXL_OVF_BIT] = 1'b1;
      end else begin
        tx_mem_we    = 1'b1;
        st_nxt.tx_wp = st_r.tx_wp + 8'h01;
      end
    end
    // Transmit engine fetch
    tx_pop       = i_tx_fetch && !tx_empty;
    st_nxt.tx_fv = tx_pop;
    if (i_tx_fetch && tx_empty) begin
      tx_set[`HFSC_TXL_UNF_BIT] = 1'b1;
    end
    if (tx_pop) begin
      st_nxt.tx_rp = st_r.tx_rp + 8'h01;
    end
    tx_cnt_n = st_r.tx_cnt + {8'h00, tx_mem_we} - {8'h00, tx_pop};
    st_nxt.tx_cnt = tx_cnt_n;

    // Real-time status from the updated counts
    st_nxt.rxs = 8'h00;
    st_nxt.rxs[`HFSC_RXS_AVAIL_BIT] = (rx_cnt_n > {1'b0, i_rx_fifo_level_ctrl});
    st_nxt.rxs[`HFSC_RXS_EMPTY_BIT] = (rx_cnt_n == 9'h000);
    st_nxt.txs = 8'h00;
    st_nxt.txs[`HFSC_TXS_AVAIL_BIT] = (tx_cnt_n < {1'b0, i_tx_fifo_level_ctrl});
    st_nxt.txs[`HFSC_TXS_FULL_BIT]  = (tx_cnt_n == 9'(`HFSC_FIFO_DEPTH));
    st_nxt.txfree = 9'(`HFSC_FIFO_DEPTH) - tx_cnt_n;

    // Rising edges of the level flags are latched events
    rx_set[`HFSC_RXL_AVAIL_BIT] = st_nxt.rxs[`HFSC_RXS_AVAIL_BIT] && !st_r.rxs[`HFSC_RXS_AVAIL_BIT];
    tx_set[`HFSC_TXL_AVAIL_BIT] = st_nxt.txs[`HFSC_TXS_AVAIL_BIT] && !st_r.txs[`HFSC_TXS_AVAIL_BIT];

    st_nxt.rxl = latch_upd(st_r.rxl, rx_set, i_rxl_clr_wr, i_rxl_clr);
    st_nxt.txl = latch_upd(st_r.txl, tx_set, i_txl_clr_wr, i_txl_clr);

    // Armed bits drive the pin until the causing bit is read
    st_nxt.rx_arm = (i_rxl_rd ? (st_r.rx_arm & ~st_r.rxl) : st_r.rx_arm) | (rx_set & i_rx_irq_enable);
    st_nxt.tx_arm = (i_txl_rd ? (st_r.tx_arm & ~st_r.txl) : st_r.tx_arm) | (tx_set & i_tx_irq_enable);
    st_nxt.rx_arm = st_nxt.rx_arm & i_rx_irq_enable;
    st_nxt.tx_arm = st_nxt.tx_arm & i_tx_irq_enable;
    st_nxt.irq_n  = !((|st_nxt.rx_arm) || (|st_nxt.tx_arm)
                      || (st_nxt.txs[`HFSC_TXS_AVAIL_BIT] && i_tx_irq_enable[`HFSC_TXL_AVAIL_BIT]));

    if (!i_nrst) begin
      st_nxt = '0;
      st_nxt.irq_n = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    st_r <= st_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  assign o_rx_rd_word           = rx_mem_rdata;
  assign o_rx_rd_valid          = st_r.rx_rd_valid;
  assign o_rx_rd_invalid        = st_r.rx_rd_inv;
  assign o_tx_fetch_data        = tx_mem_rdata.data;
  assign o_tx_fetch_valid       = st_r.tx_fv;
  assign o_rx_realtime_status   = st_r.rxs;
  assign o_tx_realtime_status   = st_r.txs;
  assign o_tx_free_count_status = st_r.txfree;
  assign o_rx_latched_status    = st_r.rxl;
  assign o_tx_latched_status    = st_r.txl;
  assign o_irq_out_n            = st_r.irq_n;
endmodule : hfsc_top

// File: tb/hfsc_chk.sv
// Purpose: Port-level assertions for hfsc_top
// Assumes: Registered status outputs, synchronous active-low reset
// Notes:   Attached to every hfsc_top by the bind at the foot
`timescale 1ns/100ps
module hfsc_chk (
  input wire logic       i_clk_sys,
  input wire logic       i_nrst,
  input wire logic [7:0] i_tx_fifo_level_ctrl,
  input wire logic [7:0] i_rx_irq_enable,
  input wire logic [7:0] i_tx_irq_enable,
  input wire logic       i_rx_rd,
  input wire logic       i_tx_wr,
  input wire logic       i_tx_fetch,
  input wire logic       i_rxl_clr_wr,
  input wire logic       i_txl_clr_wr,
  input wire logic [7:0] i_txl_clr,
  input wire logic       o_rx_rd_valid,
  input wire logic       o_rx_rd_invalid,
  input wire logic       o_tx_fetch_valid,
  input wire logic [7:0] o_rx_realtime_status,
  input wire logic [7:0] o_tx_realtime_status,
  input wire logic [8:0] o_tx_free_count_status,
  input wire logic [7:0] o_rx_latched_status,
  input wire logic [7:0] o_tx_latched_status,
  input wire logic       o_irq_out_n
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  tx_avail_a: assert property ($past(i_nrst) |-> o_tx_realtime_status[0] ==
    ((9'h100 - o_tx_free_count_status) < {1'h0, $past(i_tx_fifo_level_ctrl)})) else $error("tx avail flag wrong");
  tx_full_a: assert property ($past(i_nrst) |->
    o_tx_realtime_status[1] == (o_tx_free_count_status == 9'h000)) else $error("tx full flag wrong");
  tx_ovf_a: assert property (i_tx_wr && !i_tx_fetch && o_tx_realtime_status[1] |=>
    o_tx_latched_status[2] && o_tx_free_count_status == 9'h000) else $error("tx overflow missed");
  tx_unf_a: assert property (i_tx_fetch && !i_tx_wr && o_tx_free_count_status == 9'h100 |=>
    o_tx_latched_status[1] && !o_tx_fetch_valid) else $error("tx underflow missed");
  rx_inv_a: assert property (i_rx_rd && o_rx_realtime_status[1] |=>
    o_rx_rd_invalid && !o_rx_rd_valid && o_rx_latched_status[1]) else $error("empty read not flagged");
  ovf_hold_a: assert property (o_rx_latched_status[7] && !i_rxl_clr_wr |=>
    o_rx_latched_status[7]) else $error("latched overflow lost");
  tx_clr_a: assert property (i_txl_clr_wr && i_txl_clr[2] && !i_tx_wr |=>
    !o_tx_latched_status[2]) else $error("tx overflow not cleared");
  irq_low_a: assert property ($rose(o_tx_latched_status[1]) && $past(i_tx_irq_enable[1]) |->
    !o_irq_out_n) else $error("enabled event kept irq high");
  irq_idle_a: assert property ((i_rx_irq_enable | i_tx_irq_enable) == 8'h00 |=>
    o_irq_out_n) else $error("irq low with all enables off");
  cover property (o_rx_latched_status[7]);
  cover property (!o_irq_out_n);
  cover property (i_rx_rd && o_rx_realtime_status[1]);
endmodule : hfsc_chk
bind hfsc_top hfsc_chk chk (
  .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_tx_fifo_level_ctrl(i_tx_fifo_level_ctrl),
  .i_rx_irq_enable(i_rx_irq_enable), .i_tx_irq_enable(i_tx_irq_enable), .i_rx_rd(i_rx_rd), .i_tx_wr(i_tx_wr),
  .i_tx_fetch(i_tx_fetch), .i_rxl_clr_wr(i_rxl_clr_wr), .i_txl_clr_wr(i_txl_clr_wr), .i_txl_clr(i_txl_clr),
  .o_rx_rd_valid(o_rx_rd_valid), .o_rx_rd_invalid(o_rx_rd_invalid), .o_tx_fetch_valid(o_tx_fetch_valid),
  .o_rx_realtime_status(o_rx_realtime_status), .o_tx_realtime_status(o_tx_realtime_status),
  .o_tx_free_count_status(o_tx_free_count_status), .o_rx_latched_status(o_rx_latched_status),
  .o_tx_latched_status(o_tx_latched_status), .o_irq_out_n(o_irq_out_n));

// File: tb/hfsc_host.sv
// Purpose: Host processor model for hfsc_top
// Assumes: One-cycle strobes launched just after a rising edge
// Notes:   o_data carries tx bytes and clear masks alike
`timescale 1ns/100ps
module hfsc_host (
  input  wire logic i_clk_sys,
  output logic      o_rx_rd,
  output logic      o_tx_wr,
  output logic      o_rxl_rd,
  output logic      o_txl_rd,
  output logic      o_rxl_clr_wr,
  output logic      o_txl_clr_wr,
  output logic [7:0] o_data
);
  initial begin
    {o_rx_rd, o_tx_wr, o_rxl_rd, o_txl_rd, o_rxl_clr_wr, o_txl_clr_wr} = 6'h00;
    o_data = 8'h00;
  end
  // Kind: 0 rx pop, 1 tx push, 2/3 status read, 4/5 write-one-to-clear
  task automatic strobe(input int k, input logic [7:0] d);
    @(posedge i_clk_sys);
    o_data <= d;
    case (k)
      0: o_rx_rd <= 1'h1;
      1: o_tx_wr <= 1'h1;
      2: o_rxl_rd <= 1'h1;
      3: o_txl_rd <= 1'h1;
      4: o_rxl_clr_wr <= 1'h1;
      default: o_txl_clr_wr <= 1'h1;
    endcase
    @(posedge i_clk_sys);
    {o_rx_rd, o_tx_wr, o_rxl_rd, o_txl_rd, o_rxl_clr_wr, o_txl_clr_wr} <= 6'h00;
  endtask : strobe
endmodule : hfsc_host

// File: tb/hfsc_tb_top.sv
// Purpose: Directed self-checking bench for hfsc_top
// Assumes: Host model drives the processor side, bench drives the engine side
// Notes:   Levels are 3 for receive and 4 for transmit
`timescale 1ns/100ps
module hfsc_tb_top;
  logic                 i_clk_sys = 1'h0;
  logic                 i_nrst = 1'h0;
  logic [7:0]           i_rx_fifo_level_ctrl = 8'h03, i_tx_fifo_level_ctrl = 8'h04;
  logic [7:0]           i_rx_irq_enable = 8'h00, i_tx_irq_enable = 8'h00;
  logic                 i_rx_wr_valid = 1'h0, i_tx_fetch = 1'h0;
  hfsc_pkg::hfsc_word_t i_rx_wr_word = 10'h000, o_rx_rd_word, last;
  logic                 i_rx_rd, i_tx_wr, i_rxl_rd, i_txl_rd, i_rxl_clr_wr, i_txl_clr_wr;
  logic                 o_rx_rd_valid, o_rx_rd_invalid, o_tx_fetch_valid, o_irq_out_n;
  logic [7:0]           hd, i_tx_wr_data, i_rxl_clr, i_txl_clr, o_tx_fetch_data;
  logic [7:0]           o_rx_realtime_status, o_tx_realtime_status, o_rx_latched_status, o_tx_latched_status;
  logic [8:0]           o_tx_free_count_status;
  int                   num_errors = 0, compares = 0, cyc = 0, n;
  assign {i_tx_wr_data, i_rxl_clr, i_txl_clr} = {3{hd}};
  always #2 i_clk_sys = ~i_clk_sys;
  hfsc_host host (.i_clk_sys(i_clk_sys), .o_rx_rd(i_rx_rd), .o_tx_wr(i_tx_wr), .o_rxl_rd(i_rxl_rd),
    .o_txl_rd(i_txl_rd), .o_rxl_clr_wr(i_rxl_clr_wr), .o_txl_clr_wr(i_txl_clr_wr), .o_data(hd));
  hfsc_top dut (
    .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_rx_fifo_level_ctrl(i_rx_fifo_level_ctrl),
    .i_tx_fifo_level_ctrl(i_tx_fifo_level_ctrl), .i_rx_irq_enable(i_rx_irq_enable),
    .i_tx_irq_enable(i_tx_irq_enable), .i_rx_wr_valid(i_rx_wr_valid), .i_rx_wr_word(i_rx_wr_word),
    .i_rx_rd(i_rx_rd), .o_rx_rd_word(o_rx_rd_word), .o_rx_rd_valid(o_rx_rd_valid),
    .o_rx_rd_invalid(o_rx_rd_invalid), .i_tx_wr(i_tx_wr), .i_tx_wr_data(i_tx_wr_data),
    .i_tx_fetch(i_tx_fetch), .o_tx_fetch_data(o_tx_fetch_data), .o_tx_fetch_valid(o_tx_fetch_valid),
    .i_rxl_rd(i_rxl_rd), .i_rxl_clr_wr(i_rxl_clr_wr), .i_rxl_clr(i_rxl_clr), .i_txl_rd(i_txl_rd),
    .i_txl_clr_wr(i_txl_clr_wr), .i_txl_clr(i_txl_clr), .o_rx_realtime_status(o_rx_realtime_status),
    .o_tx_realtime_status(o_tx_realtime_status), .o_tx_free_count_status(o_tx_free_count_status),
    .o_rx_latched_status(o_rx_latched_status), .o_tx_latched_status(o_tx_latched_status),
    .o_irq_out_n(o_irq_out_n));
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic conclude;
    if (num_errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      conclude();
    end
  end
  task automatic push(input hfsc_pkg::hfsc_word_t w);
    @(posedge i_clk_sys);
    i_rx_wr_valid <= 1'h1;
    i_rx_wr_word <= w;
    @(posedge i_clk_sys);
    i_rx_wr_valid <= 1'h0;
    #1;
  endtask : push
  task automatic pop;
    host.strobe(0, 8'h00);
    #1;
  endtask : pop
  task automatic fetch1;
    @(posedge i_clk_sys);
    i_tx_fetch <= 1'h1;
    @(posedge i_clk_sys);
    i_tx_fetch <= 1'h0;
    #1;
  endtask : fetch1
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge i_clk_sys);
    i_nrst <= 1'h1;
    pop();
    chk("empty_read", {o_rx_rd_invalid, o_rx_rd_valid, o_rx_latched_status[1]}, 16'h5);
    for (int i = 0; i < 256; i++) begin
      push({i == 0, 1'h0, i[7:0]});
      if (i == 2 || i == 3) chk("rx_avail", o_rx_realtime_status[0], i == 3);
    end
    push(10'h2FF);
    chk("rx_ovf", o_rx_latched_status[7], 1'h1);
    push(10'h0AA);
    chk("rx_abort", o_rx_latched_status[2], 1'h1);
    pop();
    chk("rx_first", o_rx_rd_word, 10'h200);
    repeat (14) pop();
    push(10'h255);
    pop();
    push(10'h2A5);
    n = 0;
    repeat (300) begin
      pop();
      if (o_rx_rd_invalid === 1'h1) break;
      n++;
      last = o_rx_rd_word;
    end
    chk("rx_kept", 16'(n), 16'h00F1);
    chk("rx_last", last, 10'h2A5);
    host.strobe(4, 8'hFF);
    #1;
    chk("rx_clear", {o_rx_latched_status, o_rx_realtime_status}, 16'h0002);
    @(posedge i_clk_sys);
    i_rx_irq_enable <= 8'h02;
    pop();
    chk("rx_irq_set", o_irq_out_n, 1'h0);
    host.strobe(2, 8'h00);
    #1;
    chk("rx_irq_release", o_irq_out_n, 1'h1);
    chk("tx_avail", o_tx_realtime_status[0], 1'h1);
    @(posedge i_clk_sys);
    i_tx_irq_enable <= 8'h01;
    repeat (2) @(posedge i_clk_sys);
    #1;
    chk("irq_avail", o_irq_out_n, 0);
    @(posedge i_clk_sys);
    i_tx_irq_enable <= 8'h02;
    for (int i = 0; i < 256; i++) begin
      host.strobe(1, i[7:0]);
      #1;
      if (i == 2 || i == 3) chk("tx_avail_lvl", o_tx_realtime_status[0], i == 2);
    end
    chk("tx_full", {o_tx_realtime_status[1], o_tx_free_count_status}, 16'h200);
    host.strobe(1, 8'hEE);
    #1;
    chk("tx_ovf", {o_tx_latched_status[2], o_tx_free_count_status, o_irq_out_n}, 16'h401);
    fetch1();
    chk("tx_first", {o_tx_fetch_valid, o_tx_fetch_data}, 16'h100);
    repeat (255) fetch1();
    fetch1();
    chk("tx_unf", {o_tx_latched_status[1], o_tx_fetch_valid, o_irq_out_n}, 16'h4);
    host.strobe(3, 8'h00);
    #1;
    chk("irq_release", o_irq_out_n, 1);
    host.strobe(5, 8'h02);
    #1;
    chk("tx_clear", {o_tx_latched_status[2:1], o_tx_free_count_status}, 16'h500);
    host.strobe(5, 8'h04);
    #1;
    chk("tx_clear_ovf", o_tx_latched_status[2], 1'h0);
    conclude();
  end
endmodule : hfsc_tb_top
